// [prspp_pkg.sv]
package prspp_pkg;

    // ********************************
    // clock and timer types
    // ********************************
    localparam int CLK_HZ     = 10_000_000;       // system clock rate
    localparam int NS_PER_CYC = 1_000_000_000 / CLK_HZ;
    localparam int TW         = 20;               // wide enough for 80 ms

    typedef logic [TW-1:0] prspp_tmr_t;           // shared counter width
    typedef logic [5:0]    prspp_code_t;          // negative rail setting

    // exact ms to cycles, all figures are whole cycles at this rate
    function automatic prspp_tmr_t ms2cyc(input real ms);
        return prspp_tmr_t'(int'(ms * real'(CLK_HZ) / 1000.0));
    endfunction

    // ********************************
    // short times, in us
    // ********************************
    localparam int T_RESET_US = 100;              // logic reset interval
    localparam int T_STORE_US = 40;               // storage / turn-off period
    // least times: round up to whole cycles
    localparam prspp_tmr_t RESET_CYC =
        prspp_tmr_t'((T_RESET_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC);
    localparam prspp_tmr_t STORE_CYC =
        prspp_tmr_t'((T_STORE_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC);

    // ********************************
    // long times, in ms
    // ********************************
    localparam real T_SOFT_MS      = 1.5;         // analog soft-start ramp
    localparam real T_POS_STD_MS   = 40.0;        // positive start check
    localparam real T_POS_FAST_MS  = 10.0;
    localparam real T_NSTA_STD_MS  = 40.0;        // negative rail start delay
    localparam real T_NSTA_FAST_MS = 10.0;
    localparam real T_NCHK_STD_MS  = 80.0;        // negative start check
    localparam real T_NCHK_FAST_MS = 20.0;
    localparam real T_RUN_STD_MS   = 4.0;         // operating detect delay
    localparam real T_RUN_FAST_MS  = 1.0;

    localparam prspp_tmr_t SOFT_CYC      = ms2cyc(T_SOFT_MS);
    localparam prspp_tmr_t POS_STD_CYC   = ms2cyc(T_POS_STD_MS);
    localparam prspp_tmr_t POS_FAST_CYC  = ms2cyc(T_POS_FAST_MS);
    localparam prspp_tmr_t NSTA_STD_CYC  = ms2cyc(T_NSTA_STD_MS);
    localparam prspp_tmr_t NSTA_FAST_CYC = ms2cyc(T_NSTA_FAST_MS);
    localparam prspp_tmr_t NCHK_STD_CYC  = ms2cyc(T_NCHK_STD_MS);
    localparam prspp_tmr_t NCHK_FAST_CYC = ms2cyc(T_NCHK_FAST_MS);
    localparam prspp_tmr_t RUN_STD_CYC   = ms2cyc(T_RUN_STD_MS);
    localparam prspp_tmr_t RUN_FAST_CYC  = ms2cyc(T_RUN_FAST_MS);

    // ********************************
    // setting codes and reset values
    // ********************************
    localparam prspp_code_t CODE_DEFAULT = 6'h00;  // -2.5 V
    localparam prspp_code_t CODE_MAX     = 6'h29;  // 41 edges, -1.4 V

    // ********************************
    // carriers and states
    // ********************************
    typedef struct packed {
        logic fast_variant;        // 1: short timing set
        logic uvlo;                // input undervoltage active
        logic over_temp;           // thermal flag
        logic analog_ok;           // analog rail at or above 90 %
        logic pos_ok;              // positive rail in regulation
        logic neg_ok;              // negative rail in regulation
        logic discharge_select;    // 1: discharge when off
        logic analog_rail_enable;  // analog rail enable pin
        logic pulse_prog;          // enable and programming pin
    } prspp_pins_s;

    typedef struct packed {
        logic       analog_en;     // analog converter running
        logic       analog_soft;   // soft-start ramp active
        logic       analog_lim_red;// reduced switch limit after ramp
        logic       pos_en;        // positive converter running
        logic       pos_lim_low;   // 0.1 A start limit
        logic       neg_en;        // negative converter running
        logic       neg_lim_low;   // 0.4 A start limit
        logic [2:0] discharge;     // {analog, neg, pos} active discharge
        logic       fault;         // latched short shutdown
    } prspp_ctl_s;

    typedef enum logic [1:0] {SEQ_OFF, SEQ_POS, SEQ_NEG, SEQ_RUN} prspp_seq_e;

endpackage

// [prspp_sequencer.sv]
`timescale 1ns/1ps
// How it works
// - pin low reset interval restores default
// - counted setting stored after storage period
// - rising edges pick 41 negative settings
// - no pulses means default negative setting
// - power loss returns settings, latch default
// - analog soft-start 1.5 ms, then limit
// - positive rail starts at low limit
// - negative rail starts after fixed delay
// - negative rail late means shutdown
// - analog checks armed after soft-start
// - analog or positive sag shuts down
// - negative rail rise shuts down
// - short latches whole device off
// - latch clears on power or both low
// - disabled outputs discharge per select pin
// - first rising edge enables discharge selection
// - over-temperature pauses, keeps settings, restarts
// - undervoltage keeps device disabled
module prspp_sequencer
    import prspp_pkg::*;
#(
    parameter prspp_tmr_t P_SOFT      = SOFT_CYC,
    parameter prspp_tmr_t P_POS_STD   = POS_STD_CYC,
    parameter prspp_tmr_t P_POS_FAST  = POS_FAST_CYC,
    parameter prspp_tmr_t P_NSTA_STD  = NSTA_STD_CYC,
    parameter prspp_tmr_t P_NSTA_FAST = NSTA_FAST_CYC,
    parameter prspp_tmr_t P_NCHK_STD  = NCHK_STD_CYC,
    parameter prspp_tmr_t P_NCHK_FAST = NCHK_FAST_CYC,
    parameter prspp_tmr_t P_RUN_STD   = RUN_STD_CYC,
    parameter prspp_tmr_t P_RUN_FAST  = RUN_FAST_CYC
) (
    // clock and power-on reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // pins and analog flags
    input  wire prspp_pins_s pins_i,
    // converter control
    output prspp_ctl_s       ctl_o,
    output prspp_code_t      neg_code_o
);

    // ********************************
    // timer helper
    // ********************************
    // saturating count, so idle timers never wrap into a false event
    function automatic prspp_tmr_t tick(input prspp_tmr_t t, input prspp_tmr_t lim);
        return (t < lim) ? prspp_tmr_t'(t + 1'b1) : t;
    endfunction

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // ********************************
    // pin sampling
    // ********************************
    prspp_pins_s s1;   // first stage, read only by s2
    prspp_pins_s s2;   // second stage
    prspp_pins_s s3;   // third stage
    prspp_pins_s pin;  // accepted level
    prspp_pins_s next_pin;

    // a bit changes only once stages two and three agree
    assign next_pin = prspp_pins_s'((~(s2 ^ s3) & s3) | ((s2 ^ s3) & pin));

    // sampler runs free on the internal timebase
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            pin <= '0;
        end else begin
            s1  <= pins_i;
            s2  <= s1;
            s3  <= s2;
            pin <= next_pin;
        end
    end

    // ********************************
    // pin timing
    // ********************************
    logic       pp_q;      // last accepted pulse level
    prspp_tmr_t low_t;     // cycles pin low
    prspp_tmr_t both_t;    // cycles both enables low
    prspp_tmr_t idle_t;    // cycles since last rising edge
    wire        rise      = pin.pulse_prog & ~pp_q;
    wire        was_on    = low_t < STORE_CYC;       // low gap shorter than off delay
    wire        ctrl_on   = pin.pulse_prog | was_on;
    wire        low_rst   = low_t == RESET_CYC;
    wire        both_rst  = both_t == RESET_CYC;
    wire        store_evt = idle_t == STORE_CYC - 1'b1;
    wire        both_low  = ~pin.pulse_prog & ~pin.analog_rail_enable;

    // counters start saturated: no edge yet, device counts as reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pp_q   <= 1'b0;
            low_t  <= RESET_CYC;
            both_t <= RESET_CYC;
            idle_t <= STORE_CYC;
        end else begin
            pp_q   <= pin.pulse_prog;
            low_t  <= pin.pulse_prog ? '0 : tick(low_t, RESET_CYC);
            both_t <= both_low ? tick(both_t, RESET_CYC) : '0;
            idle_t <= rise ? '0 : tick(idle_t, STORE_CYC);
        end
    end

    // ********************************
    // edge counter and stored setting
    // ********************************
    prspp_code_t edge_cnt;  // edges in the current burst
    prspp_code_t code;      // applied setting, 0 is default
    logic        dis_valid; // discharge selection enabled
    // the enabling edge itself selects nothing
    wire         cnt_edge  = rise & was_on;
    wire         clr_code  = low_rst | pin.uvlo;
    wire         take_code = store_evt & (edge_cnt != CODE_DEFAULT);
    wire         edge_inc  = cnt_edge & (edge_cnt < CODE_MAX);
    prspp_code_t next_edge;
    prspp_code_t next_code;

    assign next_edge = (clr_code | store_evt) ? CODE_DEFAULT :
                       edge_inc ? prspp_code_t'(edge_cnt + 1'b1) : edge_cnt;
    assign next_code = clr_code ? CODE_DEFAULT :
                       take_code ? edge_cnt : code;

    // over-temperature leaves these alone, so settings survive it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            edge_cnt  <= CODE_DEFAULT;
            code      <= CODE_DEFAULT;
            dis_valid <= 1'b0;
        end else begin
            edge_cnt  <= next_edge;
            code      <= next_code;
            dis_valid <= dis_valid | rise;
        end
    end

    AST_STORE_CODE: assert property ((take_code && !clr_code) |=> code == $past(edge_cnt))
        else $error("stored setting differs from counted edges");
    AST_CODE_SAT: assert property (edge_cnt <= CODE_MAX && code <= CODE_MAX)
        else $error("edge count passed the top setting");
    AST_LOW_RESET: assert property (low_rst |=> code == CODE_DEFAULT)
        else $error("setting not defaulted after long low");

    // ********************************
    // run gating and variant timing
    // ********************************
    logic fault;  // latched short shutdown
    // thermal and undervoltage pause the converters, fault stops them
    wire  run = ~pin.uvlo & ~pin.over_temp & ~fault;
    prspp_tmr_t pos_c;
    prspp_tmr_t nsta_c;
    prspp_tmr_t nchk_c;
    prspp_tmr_t run_c;

    assign pos_c  = pin.fast_variant ? P_POS_FAST  : P_POS_STD;
    assign nsta_c = pin.fast_variant ? P_NSTA_FAST : P_NSTA_STD;
    assign nchk_c = pin.fast_variant ? P_NCHK_FAST : P_NCHK_STD;
    assign run_c  = pin.fast_variant ? P_RUN_FAST  : P_RUN_STD;

    // ********************************
    // analog rail
    // ********************************
    prspp_tmr_t a_t;    // soft-start progress
    prspp_tmr_t a_bad;  // cycles below 90 % while armed
    wire        a_on   = run & pin.analog_rail_enable;
    wire        a_done = a_t == P_SOFT;
    wire        a_arm  = a_on & a_done;
    wire        a_flt  = a_bad == run_c;

    // timers restart from zero whenever the rail is not running
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            a_t   <= '0;
            a_bad <= '0;
        end else begin
            a_t   <= a_on ? tick(a_t, P_SOFT) : '0;
            a_bad <= (a_arm & ~pin.analog_ok) ? tick(a_bad, run_c) : '0;
        end
    end

    // ********************************
    // pulse-driven rails
    // ********************************
    prspp_seq_e seq;
    prspp_seq_e next_seq;
    prspp_tmr_t c_t;      // cycles since enable
    prspp_tmr_t p_bad;    // positive rail sag time
    prspp_tmr_t n_bad;    // negative rail rise time
    logic       pos_hit;  // positive rail reached regulation
    logic       neg_hit;  // negative rail reached regulation
    wire        c_on   = run & ctrl_on;
    wire        p_arm  = (seq != SEQ_OFF) & (c_t >= pos_c);
    wire        p_late = (seq != SEQ_OFF) & (c_t == pos_c) & ~pin.pos_ok;
    wire        n_late = (seq == SEQ_NEG) & (c_t == nchk_c) & ~pin.neg_ok;
    wire        p_flt  = p_bad == run_c;
    wire        n_flt  = n_bad == run_c;

    // sequence restarts from off after any pause; thermal keeps settings, undervoltage clears them
    always_comb begin
        next_seq = seq;
        unique case (seq)
            SEQ_OFF: if (c_on) next_seq = SEQ_POS;
            SEQ_POS: if (!c_on) next_seq = SEQ_OFF;
                     else if (c_t == nsta_c) next_seq = SEQ_NEG;
            SEQ_NEG: if (!c_on) next_seq = SEQ_OFF;
                     else if (c_t == nchk_c) next_seq = SEQ_RUN;
            SEQ_RUN: if (!c_on) next_seq = SEQ_OFF;
        endcase
    end

    // sequence state and start timer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seq <= SEQ_OFF;
            c_t <= '0;
        end else begin
            seq <= next_seq;
            c_t <= c_on ? tick(c_t, nchk_c) : '0;
        end
    end

    // operating checks and start-limit release
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            p_bad   <= '0;
            n_bad   <= '0;
            pos_hit <= 1'b0;
            neg_hit <= 1'b0;
        end else begin
            p_bad   <= (p_arm & ~pin.pos_ok) ? tick(p_bad, run_c) : '0;
            n_bad   <= ((seq == SEQ_RUN) & ~pin.neg_ok) ? tick(n_bad, run_c) : '0;
            pos_hit <= (seq != SEQ_OFF) & (pos_hit | pin.pos_ok);
            neg_hit <= (seq >= SEQ_NEG) & (neg_hit | pin.neg_ok);
        end
    end

    // ********************************
    // fault latch
    // ********************************
    wire fault_evt = a_flt | p_flt | n_flt | p_late | n_late;
    wire fault_clr = both_rst | pin.uvlo;

    // a new short wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault <= 1'b0;
        end else begin
            fault <= fault_evt | (fault & ~fault_clr);
        end
    end

    AST_FAULT_HOLD: assert property (fault && !fault_clr |=> fault)
        else $error("fault latch dropped without a clear");
    AST_FAULT_SET: assert property (fault_evt |=> fault)
        else $error("short did not latch");

    // ********************************
    // outputs
    // ********************************
    prspp_ctl_s ctl;
    prspp_ctl_s next_ctl;
    wire        p_en = run & (seq != SEQ_OFF);
    wire        n_en = run & ((seq == SEQ_NEG) | (seq == SEQ_RUN));
    // discharge only once selection is live, and only for idle rails
    wire        dsel = dis_valid & pin.discharge_select;

    assign next_ctl = '{
        analog_en:      a_on,
        analog_soft:    a_on & ~a_done,
        analog_lim_red: a_arm,
        pos_en:         p_en,
        pos_lim_low:    p_en & ~pos_hit,
        neg_en:         n_en,
        neg_lim_low:    n_en & ~neg_hit,
        discharge:      {dsel & ~a_on, dsel & ~n_en, dsel & ~p_en},
        fault:          fault
    };

    // registered so converter controls never glitch
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl <= '0;
        end else begin
            ctl <= next_ctl;
        end
    end

    assign ctl_o      = ctl;
    assign neg_code_o = code;

    AST_FAULT_OFF: assert property (fault |=> !ctl.analog_en && !ctl.pos_en && !ctl.neg_en)
        else $error("rail running while fault latched");
    AST_UVLO_OFF: assert property (pin.uvlo |=> !ctl.analog_en && !ctl.pos_en && !ctl.neg_en)
        else $error("rail running in undervoltage");
    AST_OT_KEEP: assert property (pin.over_temp && !pin.uvlo && !low_rst && !take_code
        |=> !ctl.pos_en && $stable(code))
        else $error("thermal pause lost setting or left rail on");
    AST_NEG_DELAY: assert property ($rose(ctl.neg_en) |-> $past(c_t, 2) == nsta_c)
        else $error("negative rail started at wrong delay");
    AST_SOFT_END: assert property ($rose(ctl.analog_lim_red) |-> $past(ctl.analog_soft)
        && a_t == P_SOFT)
        else $error("analog limit set without finished ramp");
    AST_DISCH: assert property (!dis_valid |=> ctl.discharge == 3'h0)
        else $error("discharge before first rising edge");

    COV_STORE: cover property (take_code && edge_cnt == CODE_MAX);
    COV_FAULT: cover property ($rose(fault));
    COV_RUN:   cover property (seq == SEQ_RUN && ctl.neg_en && !ctl.neg_lim_low);

endmodule // prspp_sequencer

// [prspp_host.sv]
`timescale 1ns/1ps
// ****************************************
// host controller model
// ****************************************
module prspp_host (
    // clock
    input  wire logic clk_i,
    // pins toward the device
    output logic      pulse_prog_o,
    output logic      analog_rail_enable_o
);
    // both pins start low, device off
    initial begin
        pulse_prog_o         = 1'b0;
        analog_rail_enable_o = 1'b0;
    end
    // wait n edges, then settle just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask
    // change both pin levels together
    task automatic set(input logic pp, input logic ae);
        pulse_prog_o         = pp;
        analog_rail_enable_o = ae;
    endtask
    // n pulses of 10 us phases, pin left high
    task automatic pulses(input int n);
        repeat (n) begin
            pulse_prog_o = 1'b0; // low phase within 2..25 us
            cyc(100);
            pulse_prog_o = 1'b1; // high phase within 2..25 us
            cyc(100);
        end
    endtask
    // both low well past the reset interval
    task automatic rest();
        set(1'b0, 1'b0); // held low at least 100 us
        cyc(1100);
    endtask
endmodule // prspp_host

// [panel_rail_sequencer_pulse_prog_test.sv]
`timescale 1ns/1ps
module panel_rail_sequencer_pulse_prog_test
    import prspp_pkg::*;
;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        clk_i;
    logic        reset_n_i;
    logic        uvlo, ot, aok, pok, nok, dsel; // analog flags, discharge select pin
    logic        fast;                          // timing set strap
    wire         pp, ae;                        // host pins
    prspp_pins_s pins;
    prspp_ctl_s  ctl;
    prspp_code_t code;
    int          failures, total_checks;
    // strap driven, so both timing sets are exercised
    assign pins = {fast, uvlo, ot, aok, pok, nok, dsel, ae, pp};
    // shortened timers keep the run small; fast set differs from standard
    prspp_sequencer #(.P_SOFT(50), .P_POS_STD(200), .P_POS_FAST(100),
        .P_NSTA_STD(150), .P_NSTA_FAST(80), .P_NCHK_STD(400),
        .P_NCHK_FAST(200), .P_RUN_STD(30), .P_RUN_FAST(15)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .pins_i(pins),
        .ctl_o(ctl), .neg_code_o(code));
    prspp_host host (.clk_i(clk_i), .pulse_prog_o(pp),
        .analog_rail_enable_o(ae));
    // 100 ns clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin // x never matches
            failures++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    // defaults, no discharge before the first rise
    task automatic t_reset();
        chk("ctl", ctl, 0);
        chk("code", code, 0);
        host.set(1'b0, 1'b1); // analog only, no rise
        host.cyc(20);
        chk("dis", ctl.discharge, 0);
        host.rest();
    endtask
    // start sequence, sag check and latch clearing
    task automatic t_seq();
        host.set(1'b1, 1'b1);
        host.cyc(20);
        chk("aen", ctl.analog_en, 1);
        chk("soft", ctl.analog_soft, 1);
        chk("pos", {ctl.pos_en, ctl.pos_lim_low}, 3);
        host.cyc(20);
        chk("early", ctl.fault, 0);
        aok = 1'b1;
        host.cyc(40);
        chk("ramp", {ctl.analog_soft, ctl.analog_lim_red}, 1);
        pok = 1'b1;
        host.cyc(60);
        chk("plim", ctl.pos_lim_low, 0);
        chk("nen0", ctl.neg_en, 0);
        host.cyc(30);
        chk("nen1", {ctl.neg_en, ctl.neg_lim_low}, 3);
        nok = 1'b1;
        host.cyc(280);
        chk("nlim", {ctl.neg_lim_low, ctl.fault}, 0);
        aok = 1'b0;
        host.cyc(20);
        aok = 1'b1;
        host.cyc(40);
        chk("glitch", ctl.fault, 0);
        aok = 1'b0;
        host.cyc(60);
        aok = 1'b1;
        chk("sag", ctl.fault, 1);
        chk("off", {ctl.analog_en, ctl.pos_en, ctl.neg_en}, 0);
        host.set(1'b0, 1'b1);
        host.cyc(1100);
        chk("held", ctl.fault, 1);
        host.rest();
        chk("clear", ctl.fault, 0);
    endtask
    // start-up checks on late rails, operating rise
    task automatic t_late(input logic p, input int t0, input int t1);
        pok = p;
        nok = 1'b0;
        host.set(1'b1, 1'b0);
        host.cyc(t0);
        chk("pre", ctl.fault, 0);
        host.cyc(t1 - t0);
        chk("late", ctl.fault, 1);
        chk("down", {ctl.pos_en, ctl.neg_en}, 0);
        host.rest();
        pok = 1'b1;
    endtask
    task automatic t_rise();
        nok = 1'b1;
        host.set(1'b1, 1'b0);
        host.cyc(450);
        nok = 1'b0;
        host.cyc(60);
        nok = 1'b1;
        chk("rise", ctl.fault, 1);
        host.rest();
    endtask
    // fast timing set: earlier negative start and earlier late check
    task automatic t_fast();
        fast = 1'b1;
        nok = 1'b0;
        host.set(1'b1, 1'b0);
        host.cyc(90);
        chk("fnen", {ctl.neg_en, ctl.fault}, 16'h2);
        host.cyc(100);
        chk("fpre", ctl.fault, 16'h0);
        host.cyc(25);
        chk("flate", ctl.fault, 16'h1);
        fast = 1'b0;
        host.rest();
        nok = 1'b1;
    endtask
    // counted settings, store timing, saturation, reset, default
    task automatic t_prog();
        int n[3] = '{3, 41, 45};
        int e[3] = '{3, 41, 41};
        int p;
        p = 0;
        host.set(1'b1, 1'b0);
        host.cyc(500);
        foreach (n[i]) begin
            host.pulses(n[i]);
            host.cyc(280);
            chk("hold", code, p);
            host.cyc(50);
            chk("code", code, e[i]);
            p = e[i];
            host.cyc(300);
        end
        host.set(1'b0, 1'b1);
        host.cyc(1100);
        chk("dflt", code, 0);
        host.set(1'b1, 1'b0);
        host.cyc(600);
        chk("noprog", {ctl.pos_en, 6'(code)}, 16'h40);
    endtask
    // thermal pause keeps the setting, then power loss clears it
    task automatic t_hot();
        host.pulses(5);
        host.cyc(350);
        ot = 1'b1;
        host.cyc(20);
        chk("hot", {ctl.pos_en, 6'(code)}, 5);
        ot = 1'b0;
        host.cyc(200);
        chk("back", {ctl.neg_en, 6'(code)}, 16'h45);
        host.set(1'b0, 1'b0);
        reset_n_i = 1'b0;
        host.cyc(2);
        reset_n_i = 1'b1;
        host.cyc(2);
        chk("pwr", {ctl.fault, 6'(code)}, 0);
    endtask
    // undervoltage holds off and clears the setting
    task automatic t_uv();
        host.set(1'b1, 1'b0);
        host.cyc(500);
        host.pulses(2);
        host.cyc(350);
        uvlo = 1'b1;
        host.cyc(500);
        chk("uv", {ctl.pos_en, ctl.neg_en, 6'(code)}, 0);
        uvlo = 1'b0;
        host.rest();
    endtask
    // discharge follows the select pin when idle
    task automatic t_dis();
        chk("d1", ctl.discharge, 3'h7);
        dsel = 1'b0;
        host.cyc(10);
        chk("d0", ctl.discharge, 0);
        dsel = 1'b1;
        host.set(1'b1, 1'b0);
        host.cyc(20);
        chk("dpos", ctl.discharge, 3'h6);
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        reset_n_i = 1'b0;
        {uvlo, ot, aok, pok, nok, fast} = '0;
        dsel = 1'b1;
        failures = 0;
        total_checks = 0;
        host.cyc(20);
        reset_n_i = 1'b1;
        host.cyc(2);
        t_reset();
        t_seq();
        t_late(1'b0, 185, 215);
        t_late(1'b1, 380, 420);
        t_rise();
        t_fast();
        t_prog();
        t_hot();
        t_uv();
        t_dis();
        tally_and_finish();
    end
    initial begin
        #(100 * 60000);
        failures++;
        tally_and_finish();
    end
endmodule // panel_rail_sequencer_pulse_prog_test
